// file: verilog/rcar_regs.sv
/*
  register block of the clock, calendar and alarm unit: avalon-mm slave,
  pointer windows, write lock with key sequence, alarm and pin select.
  assumes por_rst and sys_rst are synchronous to ref_clk and that the
  reference oscillators and select strap arrive as unrelated levels.
*/
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module rcar_regs
  import rcar_pkg::*;
(
  // clock and resets
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        por_rst,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // reference oscillators and select strap
  input  wire logic        secondary_crystal_osc,
  input  wire logic        low_power_rc_osc,
  input  wire logic        reference_clock_select,
  // clock output pin and alarm event
  output logic             clock_pin_out,
  output logic             clock_pin_oe_n,
  output logic             alarm_event
);
  import rcar_pkg::*;

  logic        resp_r, rd_acc, wr_acc, lo_we, hi_we;
  logic        en_r, unl_r, oe_r;
  logic [1:0]  tptr_r, aptr_r, pin_sel_r;
  logic [7:0]  trim_r, rpt_r, yr_r;
  logic [6:0]  sec_r, min_r, a_sec_r, a_min_r;
  logic [5:0]  hr_r, day_r, a_hr_r, a_day_r;
  logic [4:0]  mon_r, a_mon_r;
  logic [2:0]  wd_r, a_wd_r;
  logic        al_on_r, chime_r, al_tog_r, tick_d_r, half_d_r;
  rcar_mask_t  ivl_r;
  rcar_key_t   key_r;
  logic [2:0]  sync_lv;
  logic        ref_lvl, ref_d_r, ref_tick;
  logic        sec_tick, half_tick, half_flag, ripple_flag;
  logic        half_clr, match, alarm_ev, pin_src;
  logic        tw_rd, tw_hi_wr, aw_rd, aw_hi_wr, sec_wrap, min_wrap;
  logic        tw_lo_we, tw_hi_we, aw_lo_we, aw_hi_we;
  logic        cfg_lo_we, cfg_hi_we, acfg_lo_we, acfg_hi_we;
  logic [15:0] rd_mux;

  // bcd step with wrap at mx
  function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] mx);
    if (v == mx) begin
      return 8'h00;
    end else if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end else begin
      return v + 8'h01;
    end
  endfunction

  // one wait state: read data stands at the accepting edge
  assign avs_waitrequest = (avs_read | avs_write) & ~resp_r;
  assign rd_acc = avs_read & resp_r;
  assign wr_acc = avs_write & resp_r;
  assign lo_we = wr_acc & avs_byteenable[0];
  assign hi_we = wr_acc & avs_byteenable[1];

  assign cfg_lo_we  = lo_we && (avs_address == OFS_CFG);
  assign cfg_hi_we  = hi_we && (avs_address == OFS_CFG);
  assign acfg_lo_we = lo_we && (avs_address == OFS_ACFG);
  assign acfg_hi_we = hi_we && (avs_address == OFS_ACFG);
  assign tw_lo_we   = lo_we && (avs_address == OFS_TWIN);
  assign tw_hi_we   = hi_we && (avs_address == OFS_TWIN);
  assign aw_lo_we   = lo_we && (avs_address == OFS_AWIN);
  assign aw_hi_we   = hi_we && (avs_address == OFS_AWIN);
  // byte and word reads look alike, so any window read steps
  assign tw_rd    = rd_acc && (avs_address == OFS_TWIN);
  assign aw_rd    = rd_acc && (avs_address == OFS_AWIN);
  assign tw_hi_wr = tw_hi_we;
  assign aw_hi_wr = aw_hi_we;
  assign half_clr = tw_lo_we && (tptr_r == PTR_MS);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      resp_r       <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      resp_r <= (avs_read | avs_write) & ~resp_r;
      if (avs_read && !resp_r) begin
        avs_readdata <= {16'h0000, rd_mux};
      end
    end
  end

  always_comb begin
    rd_mux = 16'h0000;
    unique case (avs_address)
      OFS_CFG: rd_mux = {en_r, 1'b0, unl_r, ripple_flag, half_flag, oe_r,
                         tptr_r, trim_r};
      OFS_TWIN: begin
        unique case (tptr_r)
          PTR_MS: rd_mux = {1'b0, min_r, 1'b0, sec_r};
          PTR_WH: rd_mux = {5'h00, wd_r, 2'h0, hr_r};
          PTR_MD: rd_mux = {3'h0, mon_r, 2'h0, day_r};
          PTR_YR: rd_mux = {8'h00, yr_r};
        endcase
      end
      OFS_AWIN: begin
        unique case (aptr_r)
          PTR_MS: rd_mux = {1'b0, a_min_r, 1'b0, a_sec_r};
          PTR_WH: rd_mux = {5'h00, a_wd_r, 2'h0, a_hr_r};
          PTR_MD: rd_mux = {3'h0, a_mon_r, 2'h0, a_day_r};
          PTR_YR: rd_mux = 16'h0000;
        endcase
      end
      OFS_ACFG: rd_mux = {al_on_r, chime_r, ivl_r, aptr_r, rpt_r};
      OFS_PAD:  rd_mux = {13'h0000, pin_sel_r, 1'b0};
      default:  rd_mux = 16'h0000;
    endcase
  end

  // unlock key: 55h then aah arms exactly the next bus write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      key_r <= RCAR_K_IDLE;
    end else if (wr_acc) begin
      if (lo_we && avs_address == OFS_KEY &&
          avs_writedata[7:0] == KEY_FIRST) begin
        key_r <= RCAR_K_GOT1;
      end else if (lo_we && avs_address == OFS_KEY &&
                   avs_writedata[7:0] == KEY_SECOND &&
                   key_r == RCAR_K_GOT1) begin
        key_r <= RCAR_K_ARMED;
      end else begin
        key_r <= RCAR_K_IDLE;
      end
    end
  end

  // config keeps its state across system resets
  always_ff @(posedge ref_clk) begin
    if (por_rst) begin
      en_r   <= 1'b0;
      unl_r  <= 1'b0;
      oe_r   <= 1'b0;
      tptr_r <= PTR_MS;
      trim_r <= 8'h00;
    end else begin
      if (cfg_hi_we) begin
        oe_r   <= avs_writedata[B_OE];
        tptr_r <= avs_writedata[9:8];
        if (unl_r) begin
          en_r <= avs_writedata[B_EN];
        end
        // clearing is always allowed, setting only when armed
        unl_r <= avs_writedata[B_UNL] &
                 (unl_r | (key_r == RCAR_K_ARMED));
      end else if ((tw_rd || tw_hi_wr) && tptr_r != PTR_MS) begin
        tptr_r <= tptr_r - 2'h1;
      end
      if (cfg_lo_we) begin
        trim_r <= avs_writedata[7:0];
      end
    end
  end

  assign sec_wrap = ({1'b0, sec_r} == SEC_MAX);
  assign min_wrap = ({1'b0, min_r} == SEC_MAX);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sec_r <= '0;
      min_r <= '0;
      hr_r  <= '0;
      wd_r  <= '0;
      day_r <= '0;
      mon_r <= '0;
      yr_r  <= '0;
    end else begin
      if (sec_tick) begin
        sec_r <= 7'(bcd_inc({1'b0, sec_r}, SEC_MAX));
        if (sec_wrap) begin
          min_r <= 7'(bcd_inc({1'b0, min_r}, SEC_MAX));
          if (min_wrap) begin
            hr_r <= 6'(bcd_inc({2'h0, hr_r}, HR_MAX));
            if ({2'h0, hr_r} == HR_MAX) begin
              wd_r <= (wd_r == WD_MAX) ? 3'h0 : wd_r + 3'h1;
            end
          end
        end
      end
      if (tw_lo_we && unl_r) begin
        unique case (tptr_r)
          PTR_MS: sec_r <= avs_writedata[6:0];
          PTR_WH: hr_r  <= avs_writedata[5:0];
          PTR_MD: day_r <= avs_writedata[5:0];
          PTR_YR: yr_r  <= avs_writedata[7:0];
        endcase
      end
      if (tw_hi_we && unl_r) begin
        unique case (tptr_r)
          PTR_MS: min_r <= avs_writedata[14:8];
          PTR_WH: wd_r  <= avs_writedata[10:8];
          PTR_MD: mon_r <= avs_writedata[12:8];
          PTR_YR: ;
        endcase
      end
    end
  end

  // compare one cycle after the tick, against the advanced time
  always_comb begin
    unique case (ivl_r)
      RCAR_M_HALF, RCAR_M_SEC: match = 1'b1;
      RCAR_M_10S:   match = (sec_r[3:0] == a_sec_r[3:0]);
      RCAR_M_MIN:   match = (sec_r == a_sec_r);
      RCAR_M_10M:   match = (sec_r == a_sec_r) &&
                            (min_r[3:0] == a_min_r[3:0]);
      RCAR_M_HOUR:  match = (sec_r == a_sec_r) && (min_r == a_min_r);
      RCAR_M_DAY:   match = (sec_r == a_sec_r) && (min_r == a_min_r) &&
                            (hr_r == a_hr_r);
      RCAR_M_WEEK:  match = (sec_r == a_sec_r) && (min_r == a_min_r) &&
                            (hr_r == a_hr_r) && (wd_r == a_wd_r);
      RCAR_M_MONTH: match = (sec_r == a_sec_r) && (min_r == a_min_r) &&
                            (hr_r == a_hr_r) && (day_r == a_day_r);
      RCAR_M_YEAR:  match = (sec_r == a_sec_r) && (min_r == a_min_r) &&
                            (hr_r == a_hr_r) && (day_r == a_day_r) &&
                            (mon_r == a_mon_r);
      default:      match = 1'b0;
    endcase
  end

  assign alarm_ev = al_on_r && match &&
                    (tick_d_r || (half_d_r && ivl_r == RCAR_M_HALF));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_d_r <= 1'b0;
      half_d_r <= 1'b0;
      al_on_r  <= 1'b0;
      chime_r  <= 1'b0;
      ivl_r    <= RCAR_M_HALF;
      aptr_r   <= PTR_MS;
      rpt_r    <= 8'h00;
    end else begin
      tick_d_r <= sec_tick;
      half_d_r <= half_tick;
      if (alarm_ev) begin
        if (rpt_r != 8'h00) begin
          rpt_r <= rpt_r - 8'h01;
        end else if (chime_r) begin
          rpt_r <= REPEAT_ALL;
        end else begin
          al_on_r <= 1'b0;
        end
      end
      // software write wins over the hardware update
      if (acfg_hi_we) begin
        al_on_r <= avs_writedata[B_AON];
        chime_r <= avs_writedata[B_CHIME];
        ivl_r   <= rcar_mask_t'(avs_writedata[13:10]);
        aptr_r  <= avs_writedata[9:8];
      end else if ((aw_rd || aw_hi_wr) && aptr_r != PTR_MS) begin
        aptr_r <= aptr_r - 2'h1;
      end
      if (acfg_lo_we) begin
        rpt_r <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      a_sec_r <= '0;
      a_min_r <= '0;
      a_hr_r  <= '0;
      a_wd_r  <= '0;
      a_day_r <= '0;
      a_mon_r <= '0;
    end else begin
      if (aw_lo_we) begin
        unique case (aptr_r)
          PTR_MS: a_sec_r <= avs_writedata[6:0];
          PTR_WH: if (unl_r) a_hr_r <= avs_writedata[5:0];
          PTR_MD: if (unl_r) a_day_r <= avs_writedata[5:0];
          PTR_YR: ;
        endcase
      end
      if (aw_hi_we) begin
        unique case (aptr_r)
          PTR_MS: a_min_r <= avs_writedata[14:8];
          PTR_WH: if (unl_r) a_wd_r <= avs_writedata[10:8];
          PTR_MD: if (unl_r) a_mon_r <= avs_writedata[12:8];
          PTR_YR: ;
        endcase
      end
    end
  end

  rcar_sync #(
    .W (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({reference_clock_select, secondary_crystal_osc,
                low_power_rc_osc}),
    .sync_out (sync_lv)
  );

  assign ref_lvl  = sync_lv[2] ? sync_lv[1] : sync_lv[0];
  assign ref_tick = ref_lvl & ~ref_d_r;

  rcar_timekeeper u_tk (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .ref_tick    (ref_tick),
    .run         (en_r),
    .trim        (trim_r),
    .minute_end  (sec_wrap),
    .half_clr    (half_clr),
    .sec_tick    (sec_tick),
    .half_tick   (half_tick),
    .half_flag   (half_flag),
    .ripple_flag (ripple_flag)
  );

  always_comb begin
    unique case (pin_sel_r)
      SRC_REF:    pin_src = ref_lvl;
      SRC_SECOND: pin_src = half_flag;
      SRC_ALARM:  pin_src = al_tog_r;
      default:    pin_src = 1'b0;
    endcase
  end

  // the alarm pulse toggles the pin so a slow observer still sees it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ref_d_r       <= 1'b0;
      pin_sel_r     <= SRC_ALARM;
      al_tog_r      <= 1'b0;
      alarm_event   <= 1'b0;
      clock_pin_out <= 1'b0;
    end else begin
      ref_d_r       <= ref_lvl;
      alarm_event   <= alarm_ev;
      clock_pin_out <= oe_r & pin_src;
      if (alarm_ev) begin
        al_tog_r <= ~al_tog_r;
      end
      if (lo_we && avs_address == OFS_PAD) begin
        pin_sel_r <= avs_writedata[PAD_SEL_LSB +: 2];
      end
    end
  end

  assign clock_pin_oe_n = ~oe_r;

  a_tptr_read_dec: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    (tw_rd && tptr_r != PTR_MS) |=> (tptr_r == $past(tptr_r) - 2'h1))
    else $error("time pointer did not step on window read");
  a_aptr_write_dec: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    (aw_hi_we && aptr_r != PTR_MS && !acfg_hi_we) |=>
    (aptr_r == $past(aptr_r) - 2'h1))
    else $error("alarm pointer did not step on high write");
  a_aptr_hold_zero: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    (aptr_r == PTR_MS && !acfg_hi_we) |=> (aptr_r == PTR_MS))
    else $error("alarm pointer left zero by itself");
  a_time_lock: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    (tw_lo_we && !unl_r && !sec_tick && tptr_r == PTR_MS) |=> $stable(sec_r))
    else $error("seconds written while locked");
  a_unlock_key: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    $rose(unl_r) |-> ($past(key_r) == RCAR_K_ARMED))
    else $error("unlock set without key sequence");
  a_en_locked: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    (cfg_hi_we && !unl_r) |=> $stable(en_r))
    else $error("enable changed while locked");
  a_half_clear: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    half_clr |=> !half_flag [*2])
    else $error("half flag not cleared by min-sec write");
  a_pin_off: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    (!oe_r && clock_pin_oe_n) |=> !clock_pin_out)
    else $error("pin driven while output disabled");
  a_alarm_autoclr: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    (alarm_ev && rpt_r == 8'h00 && !chime_r && !acfg_hi_we) |=>
    !al_on_r ##1 alarm_event == 1'b0)
    else $error("alarm on not cleared after last repeat");
  a_rpt_wrap: assert property (@(posedge ref_clk)
    disable iff (sys_rst || por_rst)
    (alarm_ev && rpt_r == 8'h00 && chime_r && !acfg_lo_we &&
     !acfg_hi_we) |=>
    (rpt_r == REPEAT_ALL && al_on_r == $past(al_on_r)))
    else $error("chime repeat counter did not wrap");
endmodule

// file: verilog/rcar_pkg.sv
/*
  constants for the clock, calendar and alarm register block: register
  offsets, field positions, key values, codes and timing figures.
  assumes a 32-bit avalon-mm master with byte addresses and a slow
  reference clock sampled on the 25 mhz ref_clk.
*/
package rcar_pkg;
  localparam logic [4:0] OFS_CFG  = 5'h00;
  localparam logic [4:0] OFS_TWIN = 5'h04;
  localparam logic [4:0] OFS_AWIN = 5'h08;
  localparam logic [4:0] OFS_ACFG = 5'h0c;
  localparam logic [4:0] OFS_PAD  = 5'h10;
  localparam logic [4:0] OFS_KEY  = 5'h14;
  localparam int B_EN = 15;
  localparam int B_UNL = 13;
  localparam int B_OE = 10;
  localparam int B_AON = 15;
  localparam int B_CHIME = 14;
  localparam int PAD_SEL_LSB = 1;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [1:0] PTR_MS = 2'h0;
  localparam logic [1:0] PTR_WH = 2'h1;
  localparam logic [1:0] PTR_MD = 2'h2;
  localparam logic [1:0] PTR_YR = 2'h3;
  localparam logic [1:0] SRC_ALARM = 2'h0;
  localparam logic [1:0] SRC_SECOND = 2'h1;
  localparam logic [1:0] SRC_REF = 2'h2;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HR_MAX = 8'h23;
  localparam logic [2:0] WD_MAX = 3'h6;
  localparam logic [7:0] REPEAT_ALL = 8'hff;
  localparam int REF_PER_SEC = 32768;
  localparam int RIPPLE_TICKS = 16;
  typedef enum logic [3:0] {
    RCAR_M_HALF, RCAR_M_SEC, RCAR_M_10S, RCAR_M_MIN, RCAR_M_10M,
    RCAR_M_HOUR, RCAR_M_DAY, RCAR_M_WEEK, RCAR_M_MONTH, RCAR_M_YEAR
  } rcar_mask_t;
  typedef enum logic [1:0] {
    RCAR_K_IDLE, RCAR_K_GOT1, RCAR_K_ARMED
  } rcar_key_t;
endpackage

// file: verilog/rcar_sync.sv
/*
  two-flop synchroniser for a group of slow, unrelated levels.
  assumes each bit changes far slower than ref_clk; bits are not coherent.
*/
`timescale 1ns/100ps
module rcar_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// file: verilog/rcar_timekeeper.sv
/*
  one-second prescaler on reference clock edges, with per-minute drift
  trim, half-second and ripple flags.
  assumes ref_tick is a one-cycle pulse per reference edge and that
  minute_end is high while the seconds field reads 59.
*/
`timescale 1ns/100ps
module rcar_timekeeper
  import rcar_pkg::*;
#(
  parameter int PER_SEC = REF_PER_SEC,
  parameter int PRE_W   = 17
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // control
  input  wire logic       ref_tick,
  input  wire logic       run,
  input  wire logic [7:0] trim,
  input  wire logic       minute_end,
  input  wire logic       half_clr,
  // status
  output logic            sec_tick,
  output logic            half_tick,
  output logic            half_flag,
  output logic            ripple_flag
);
  localparam logic signed [PRE_W-1:0] LAST = PRE_W'(PER_SEC - 1);
  localparam logic signed [PRE_W-1:0] HALF = PRE_W'(PER_SEC / 2);
  localparam logic signed [PRE_W-1:0] RIP = PRE_W'(PER_SEC - RIPPLE_TICKS);

  logic signed [PRE_W-1:0] pre_r;
  logic signed [PRE_W-1:0] trim_load;

  // four pulses per count: a positive start skips pulses, negative adds
  assign trim_load = {{(PRE_W - 10){trim[7]}}, trim, 2'b00};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_r     <= '0;
      sec_tick  <= 1'b0;
      half_tick <= 1'b0;
    end else begin
      sec_tick  <= 1'b0;
      half_tick <= 1'b0;
      if (half_clr) begin
        pre_r <= '0;
      end else if (run && ref_tick) begin
        if (pre_r >= LAST) begin
          sec_tick <= 1'b1;
          pre_r    <= minute_end ? trim_load : '0;
        end else begin
          pre_r     <= pre_r + PRE_W'(1);
          half_tick <= (pre_r == HALF - PRE_W'(1));
        end
      end
    end
  end

  assign half_flag   = (pre_r >= HALF);
  assign ripple_flag = run && (pre_r >= RIP);
endmodule

// file: test/rcar_regs_tb.sv
/*
  self-checking bench for rcar_regs: bus reads and writes, lock and key
  sequence, pointer windows, config kept over sys_rst, pin source, half
  flag and alarm events. assumes the package offsets and one-wait bus.
*/
`timescale 1ns/100ps
module rcar_regs_tb;
  import rcar_pkg::*;
  logic        ref_clk;
  logic        sys_rst;
  logic        por_rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        secondary_crystal_osc;
  logic        low_power_rc_osc;
  logic        reference_clock_select;
  logic        clock_pin_out;
  logic        clock_pin_oe_n;
  logic        alarm_event;
  logic        osc_run;
  logic [31:0] seed;
  logic [31:0] q;
  logic [15:0] m_cfg;
  logic [15:0] m_q[$];
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;
  int          events = 0;
  int          ev0;

  rcar_regs dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .por_rst(por_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .secondary_crystal_osc(secondary_crystal_osc),
    .low_power_rc_osc(low_power_rc_osc),
    .reference_clock_select(reference_clock_select),
    .clock_pin_out(clock_pin_out), .clock_pin_oe_n(clock_pin_oe_n),
    .alarm_event(alarm_event)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // two alarm runs of about 36k cycles each dominate the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (alarm_event === 1'b1) events <= events + 1;
    if (osc_run) secondary_crystal_osc <= ~secondary_crystal_osc;
    if (cycles == 90000) begin
      mismatches++;
      complete_run();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_byteenable <= be;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr16(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [15:0] e,
                       input string what);
    bus(1'b0, a, 16'h0, 4'h3);
    check(what, q, {16'h0, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // restart the prescaler, then look either side of the half point
  task automatic alarm_run(input logic [15:0] acfg);
    wr16(OFS_ACFG, acfg);
    bus(1'b1, OFS_TWIN, 16'h0, 4'h1);
    ev0 = events;
    idle(30000);
    rdchk(OFS_CFG, m_cfg, "first half");
    check("no event yet", events - ev0, 0);
    idle(6000);
    rdchk(OFS_CFG, m_cfg | 16'h0800, "second half");
    check("one event", events - ev0, 1);
    check("pin half flag", clock_pin_out, 1'b1);
  endtask

  initial begin
    sys_rst = 1'b1;
    por_rst = 1'b1;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    secondary_crystal_osc = 1'b1;
    low_power_rc_osc = 1'b0;
    reference_clock_select = 1'b1;
    osc_run = 1'b0;
    seed = 32'h925b496f;
    idle(6);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    rdchk(OFS_CFG, 16'h0, "cfg reset");
    rdchk(OFS_ACFG, 16'h0, "acfg reset");
    rdchk(OFS_PAD, 16'h0, "pad reset");
    rdchk(5'h18, 16'h0, "unmapped");
    rdchk(OFS_KEY, 16'h0, "key read");
    done("reset");
    // enable bit and time writes refused while locked
    wr16(OFS_CFG, 16'h8400);
    rdchk(OFS_CFG, 16'h0400, "en locked");
    idle(1);
    check("oe_n on", clock_pin_oe_n, 1'b0);
    wr16(OFS_TWIN, 16'h2345);
    rdchk(OFS_TWIN, 16'h0, "time locked");
    wr16(OFS_KEY, {8'h0, KEY_FIRST});
    wr16(OFS_PAD, 16'h0);
    wr16(OFS_KEY, {8'h0, KEY_SECOND});
    wr16(OFS_CFG, 16'h2400);
    rdchk(OFS_CFG, 16'h0400, "broken keys");
    wr16(OFS_KEY, {8'h0, KEY_FIRST});
    wr16(OFS_KEY, {8'h0, KEY_SECOND});
    wr16(OFS_CFG, 16'h2700);
    rdchk(OFS_CFG, 16'h2700, "unlocked");
    done("lock");
    for (int p = 3; p >= 0; p--) begin
      bus(1'b0, OFS_TWIN, 16'h0, 4'h2);
      m_cfg = 16'h2400 | 16'((p > 0 ? p - 1 : 0) << 8);
      rdchk(OFS_CFG, m_cfg, "time ptr read");
    end
    wr16(OFS_TWIN, 16'h2345);
    rdchk(OFS_TWIN, 16'h2345, "min-sec write");
    wr16(OFS_CFG, 16'h2500);
    wr16(OFS_TWIN, 16'h0312);
    rdchk(OFS_CFG, 16'h2400, "time ptr write");
    wr16(OFS_CFG, 16'h2500);
    rdchk(OFS_TWIN, 16'h0312, "wkday hours");
    done("time window");
    wr16(OFS_ACFG, 16'h0200);
    m_q = {16'h1225, 16'h0408, 16'h0102};
    foreach (m_q[i]) wr16(OFS_AWIN, m_q[i]);
    rdchk(OFS_ACFG, 16'h0, "alarm ptr floor");
    wr16(OFS_ACFG, 16'h0200);
    while (m_q.size() > 0) rdchk(OFS_AWIN, m_q.pop_front(), "awin");
    rdchk(OFS_AWIN, 16'h0102, "awin stays");
    wr16(OFS_ACFG, 16'h0300);
    rdchk(OFS_AWIN, 16'h0, "awin none");
    rdchk(OFS_ACFG, 16'h0200, "alarm ptr read");
    done("alarm window");
    seed = lfsr(seed);
    m_cfg = {8'ha4, seed[7:0]};
    wr16(OFS_CFG, m_cfg);
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    rdchk(OFS_CFG, m_cfg, "cfg kept");
    rdchk(OFS_ACFG, 16'h0, "acfg cleared");
    done("config reset");
    wr16(OFS_PAD, {13'h0, SRC_REF, 1'b0});
    idle(8);
    check("pin crystal", clock_pin_out, 1'b1);
    reference_clock_select <= 1'b0;
    idle(8);
    check("pin rc", clock_pin_out, 1'b0);
    reference_clock_select <= 1'b1;
    wr16(OFS_PAD, 16'h0006);
    idle(8);
    check("pin reserved", clock_pin_out, 1'b0);
    wr16(OFS_PAD, {13'h0, SRC_SECOND, 1'b0});
    done("pin");
    osc_run <= 1'b1;
    alarm_run(16'h8000);
    rdchk(OFS_ACFG, 16'h0000, "alarm off after");
    alarm_run(16'hc000);
    rdchk(OFS_ACFG, 16'hc0ff, "chime wrap");
    wr16(OFS_CFG, m_cfg & 16'hdbff);
    idle(2);
    check("oe_n off", clock_pin_oe_n, 1'b1);
    rdchk(OFS_CFG, (m_cfg & 16'hdbff) | 16'h0800, "relocked");
    done("timer");
    complete_run();
  end
endmodule
